// ===== common/bsm_pkg.sv
// Operation
// - valid cc pdu clears missed count and sets cc received flag
// - with sampling on, store remote state, diag, multiplier per session side
// - received state, diag or multiplier differing from stored sets side change flag
// - cc pdu poll or final flag sets that side's poll or final seen flag
// - valid cv pdu clears missed count, sets cv flag, sink poll/final seen
// - enabled change, poll and final flags raise the interrupt
// - copy-all enables copy every valid cc, respectively cv, pdu to cpu
// - next-good request extracts the next valid pdu of that type
// - single-shot mode extracts only next matching pdu, else every match
// - param change extraction takes cc pdus whose parameters changed
// - poll and final extraction take valid pdus carrying those flags
// - rx error extraction sends failed pdus to cpu instead of discard
// - valid extracts go to cc or cv queue, invalid to error queue
// - coordinated tx pdu matches when its discriminator equals local source
// - independent mode matches source for near end, sink for far end
// - with tx rewrite on, unmatched tx pdu is discarded, flagged, optionally extracted to error queue
// - tx rewrite overwrites diag, state, multiplier with matched side local values
// - selected miss timer expiry increments missed count, readable by software
// - miss count is one bit wider than multiplier; three misses mean six
// - continuity lost when count reaches twice session multiplier, mode selects side
// - continuity state held, change flag set on change, interrupt if enabled
// - without discriminator checking every rx pdu belongs to near end side
// - separate 32-bit counters of transmitted cc and cv pdus
package bsm_pkg;
  localparam int unsigned STATE_W = 2;
  localparam int unsigned DIAG_W  = 5;
  localparam int unsigned MULT_W  = 8;
  localparam int unsigned MISS_W  = MULT_W + 1;
  localparam int unsigned STK_W   = 14;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_EXTRACT    = 8'h04;
  localparam logic [7:0] OFS_SRC_DISCR  = 8'h08;
  localparam logic [7:0] OFS_SINK_DISCR = 8'h0C;
  localparam logic [7:0] OFS_SRC_INFO   = 8'h10;
  localparam logic [7:0] OFS_SINK_INFO  = 8'h14;
  localparam logic [7:0] OFS_STICKY     = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENA    = 8'h1C;
  localparam logic [7:0] OFS_STATUS     = 8'h20;
  localparam logic [7:0] OFS_CC_TX_CNT  = 8'h24;
  localparam logic [7:0] OFS_CV_TX_CNT  = 8'h28;

  // config fields
  localparam int unsigned CFG_SAMPLE   = 0;
  localparam int unsigned CFG_INDEP    = 1;
  localparam int unsigned CFG_DISCR_CK = 2;
  localparam int unsigned CFG_TX_RW    = 3;
  localparam int unsigned CFG_TSEL_LO  = 4;
  localparam int unsigned CFG_CC_COPY  = 6;
  localparam int unsigned CFG_CV_COPY  = 7;
  localparam int unsigned CFG_W        = 8;

  // extract fields
  localparam int unsigned EX_CC_NEXT = 0;
  localparam int unsigned EX_CV_NEXT = 1;
  localparam int unsigned EX_ONCE    = 2;
  localparam int unsigned EX_PARAM   = 3;
  localparam int unsigned EX_POLL    = 4;
  localparam int unsigned EX_FINAL   = 5;
  localparam int unsigned EX_RX_ERR  = 6;
  localparam int unsigned EX_TX_ERR  = 7;
  localparam int unsigned EX_W       = 8;

  // info word: local fields writable, remote fields read only
  localparam int unsigned INF_LSTATE = 0;
  localparam int unsigned INF_LDIAG  = 2;
  localparam int unsigned INF_LMULT  = 8;
  localparam int unsigned INF_RSTATE = 16;
  localparam int unsigned INF_RDIAG  = 18;
  localparam int unsigned INF_RMULT  = 24;

  // sticky bit positions
  localparam int unsigned STK_CC_RX      = 0;
  localparam int unsigned STK_CV_RX      = 1;
  localparam int unsigned STK_SRC_MULT   = 2;
  localparam int unsigned STK_SRC_STATE  = 3;
  localparam int unsigned STK_SRC_DIAG   = 4;
  localparam int unsigned STK_SRC_POLL   = 5;
  localparam int unsigned STK_SRC_FINAL  = 6;
  localparam int unsigned STK_SINK_MULT  = 7;
  localparam int unsigned STK_SINK_STATE = 8;
  localparam int unsigned STK_SINK_DIAG  = 9;
  localparam int unsigned STK_SINK_POLL  = 10;
  localparam int unsigned STK_SINK_FINAL = 11;
  localparam int unsigned STK_CONT_CHG   = 12;
  localparam int unsigned STK_TX_MISM    = 13;
  // bits that may drive the interrupt
  localparam logic [STK_W-1:0] IRQ_CAPABLE = 14'h1FFC;

  localparam int unsigned STATUS_LOST = 16;

  // cpu queue codes
  localparam logic [1:0] Q_CC  = 2'h0;
  localparam logic [1:0] Q_CV  = 2'h1;
  localparam logic [1:0] Q_ERR = 2'h2;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [EX_W-1:0]  EX_RESET  = 8'h00;
  localparam logic [31:0]      ZERO32    = 32'h0000_0000;
endpackage

// ===== verilog/bsm_session_monitor.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bsm_session_monitor
  import bsm_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // received pdu from frame pipeline
  input  wire logic                 rx_pdu_valid,
  input  wire logic                 rx_pdu_ok,
  input  wire logic                 rx_pdu_is_cv,
  input  wire logic                 rx_pdu_far_end,
  input  wire logic [STATE_W-1:0]   rx_state,
  input  wire logic [DIAG_W-1:0]    rx_diag,
  input  wire logic [MULT_W-1:0]    rx_mult,
  input  wire logic                 rx_poll,
  input  wire logic                 rx_final,
  // rx extraction to cpu queues
  output logic                      rx_extract_valid,
  output logic      [1:0]           rx_extract_queue,
  // transmitted pdu in
  input  wire logic                 tx_pdu_valid,
  input  wire logic                 tx_pdu_is_cv,
  input  wire logic [31:0]          tx_my_discr,
  input  wire logic [STATE_W-1:0]   tx_state,
  input  wire logic [DIAG_W-1:0]    tx_diag,
  input  wire logic [MULT_W-1:0]    tx_mult,
  // transmitted pdu out
  output logic                      tx_out_valid,
  output logic                      tx_out_discard,
  output logic      [STATE_W-1:0]   tx_out_state,
  output logic      [DIAG_W-1:0]    tx_out_diag,
  output logic      [MULT_W-1:0]    tx_out_mult,
  output logic                      tx_extract_valid,
  // miss timers and interrupt
  input  wire logic [3:0]           miss_timer_expired,
  output logic                      irq
);

  function automatic logic [31:0] info_word(
    input logic [STATE_W-1:0] ls, input logic [DIAG_W-1:0] ld, input logic [MULT_W-1:0] lm,
    input logic [STATE_W-1:0] rs, input logic [DIAG_W-1:0] rd, input logic [MULT_W-1:0] rm);
    logic [31:0] w;
    w = ZERO32;
    w[INF_LSTATE +: STATE_W] = ls;
    w[INF_LDIAG  +: DIAG_W]  = ld;
    w[INF_LMULT  +: MULT_W]  = lm;
    w[INF_RSTATE +: STATE_W] = rs;
    w[INF_RDIAG  +: DIAG_W]  = rd;
    w[INF_RMULT  +: MULT_W]  = rm;
    return w;
  endfunction

  // registers; index 0 is source/near side, 1 is sink/far side
  logic [CFG_W-1:0]                 config_reg;
  logic [EX_W-1:0]                  extract_reg;
  logic [31:0]                      local_source_discriminator;
  logic [31:0]                      local_sink_discriminator;
  logic [1:0][STATE_W-1:0]          loc_state;
  logic [1:0][DIAG_W-1:0]           loc_diag;
  logic [1:0][MULT_W-1:0]           loc_mult;
  logic [1:0][STATE_W-1:0]          rem_state;
  logic [1:0][DIAG_W-1:0]           rem_diag;
  logic [1:0][MULT_W-1:0]           rem_mult;
  logic [STK_W-1:0]                 sticky;
  logic [STK_W-1:0]                 interrupt_enable_set;
  logic [MISS_W-1:0]                missed_pdu_count;
  logic                             continuity_lost_state;
  logic [31:0]                      cc_tx_count;
  logic [31:0]                      cv_tx_count;

  // apb decode
  wire        apb_setup  = psel & ~penable;
  wire        apb_commit = psel & penable & pready;
  wire        apb_wr     = apb_commit & pwrite;
  wire        hit_cfg    = (paddr == OFS_CONFIG);
  wire        hit_ext    = (paddr == OFS_EXTRACT);
  wire        hit_sdis   = (paddr == OFS_SRC_DISCR);
  wire        hit_kdis   = (paddr == OFS_SINK_DISCR);
  wire        hit_sinf   = (paddr == OFS_SRC_INFO);
  wire        hit_kinf   = (paddr == OFS_SINK_INFO);
  wire        hit_stk    = (paddr == OFS_STICKY);
  wire        hit_ien    = (paddr == OFS_IRQ_ENA);
  wire        hit_stat   = (paddr == OFS_STATUS);
  wire        hit_cctx   = (paddr == OFS_CC_TX_CNT);
  wire        hit_cvtx   = (paddr == OFS_CV_TX_CNT);
  wire        hit_any    = hit_cfg | hit_ext | hit_sdis | hit_kdis | hit_sinf | hit_kinf |
                           hit_stk | hit_ien | hit_stat | hit_cctx | hit_cvtx;
  wire [STK_W-1:0] stk_clear = (apb_wr & hit_stk) ? pwdata[STK_W-1:0] : '0;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ZERO32;
    if (hit_cfg) begin
      rd_mux[CFG_W-1:0] = config_reg;
    end else if (hit_ext) begin
      rd_mux[EX_W-1:0] = extract_reg;
    end else if (hit_sdis) begin
      rd_mux = local_source_discriminator;
    end else if (hit_kdis) begin
      rd_mux = local_sink_discriminator;
    end else if (hit_sinf) begin
      rd_mux = info_word(loc_state[0], loc_diag[0], loc_mult[0],
                         rem_state[0], rem_diag[0], rem_mult[0]);
    end else if (hit_kinf) begin
      rd_mux = info_word(loc_state[1], loc_diag[1], loc_mult[1],
                         rem_state[1], rem_diag[1], rem_mult[1]);
    end else if (hit_stk) begin
      rd_mux[STK_W-1:0] = sticky;
    end else if (hit_ien) begin
      rd_mux[STK_W-1:0] = interrupt_enable_set;
    end else if (hit_stat) begin
      rd_mux[MISS_W-1:0]  = missed_pdu_count;
      rd_mux[STATUS_LOST] = continuity_lost_state;
    end else if (hit_cctx) begin
      rd_mux = cc_tx_count;
    end else if (hit_cvtx) begin
      rd_mux = cv_tx_count;
    end
  end

  // receive side
  wire indep   = config_reg[CFG_INDEP];
  wire rx_far  = indep & config_reg[CFG_DISCR_CK] & rx_pdu_far_end;
  wire rx_side = rx_far;
  wire cc_ok   = rx_pdu_valid & rx_pdu_ok & ~rx_pdu_is_cv;
  wire cv_ok   = rx_pdu_valid & rx_pdu_ok & rx_pdu_is_cv;
  wire rx_bad  = rx_pdu_valid & ~rx_pdu_ok;
  wire chg_m   = rx_mult  != rem_mult[rx_side];
  wire chg_s   = rx_state != rem_state[rx_side];
  wire chg_d   = rx_diag  != rem_diag[rx_side];
  wire chg_any = chg_m | chg_s | chg_d;
  wire do_sample = cc_ok & config_reg[CFG_SAMPLE];

  // extraction criteria
  wire once      = extract_reg[EX_ONCE];
  wire hit_ccnx  = cc_ok & extract_reg[EX_CC_NEXT];
  wire hit_cvnx  = cv_ok & extract_reg[EX_CV_NEXT];
  wire hit_param = cc_ok & chg_any & extract_reg[EX_PARAM];
  wire hit_poll  = (cc_ok | cv_ok) & rx_poll & extract_reg[EX_POLL];
  wire hit_final = (cc_ok | cv_ok) & rx_final & extract_reg[EX_FINAL];
  wire hit_rxerr = rx_bad & extract_reg[EX_RX_ERR];
  wire hit_ccall = cc_ok & config_reg[CFG_CC_COPY];
  wire hit_cvall = cv_ok & config_reg[CFG_CV_COPY];
  wire rx_extract = hit_ccnx | hit_cvnx | hit_param | hit_poll | hit_final |
                    hit_rxerr | hit_ccall | hit_cvall;
  wire [1:0] rx_queue = rx_bad ? Q_ERR : (rx_pdu_is_cv ? Q_CV : Q_CC);

  // transmit side
  wire tx_rw     = config_reg[CFG_TX_RW];
  wire tx_src    = tx_my_discr == local_source_discriminator;
  wire tx_sink   = indep & ~tx_src & (tx_my_discr == local_sink_discriminator);
  wire tx_mism   = tx_pdu_valid & tx_rw & ~tx_src & ~tx_sink;
  wire tx_side   = tx_sink;
  wire hit_txerr = tx_mism & extract_reg[EX_TX_ERR];

  // clears from hardware on extraction
  logic [EX_W-1:0] ex_hw_clr;
  always_comb begin
    ex_hw_clr             = '0;
    ex_hw_clr[EX_CC_NEXT] = hit_ccnx;
    ex_hw_clr[EX_CV_NEXT] = hit_cvnx;
    ex_hw_clr[EX_PARAM]   = once & hit_param;
    ex_hw_clr[EX_POLL]    = once & hit_poll;
    ex_hw_clr[EX_FINAL]   = once & hit_final;
    ex_hw_clr[EX_RX_ERR]  = once & hit_rxerr;
    ex_hw_clr[EX_TX_ERR]  = once & hit_txerr;
  end
  // a software write in the same cycle re-arms: it wins
  wire [EX_W-1:0] next_extract = (apb_wr & hit_ext) ? pwdata[EX_W-1:0] : (extract_reg & ~ex_hw_clr);

  // continuity loss; counter ticks twice per rx interval so threshold is 2x multiplier
  wire               tick      = miss_timer_expired[config_reg[CFG_TSEL_LO +: 2]];
  wire [MULT_W-1:0]  loss_mult = indep ? rem_mult[1] : rem_mult[0];
  wire [MISS_W-1:0]  loss_lim  = {loss_mult, 1'b0};
  wire               miss_max  = &missed_pdu_count;
  wire [MISS_W-1:0]  next_missed_pdu_count =
      (cc_ok | cv_ok)    ? '0 :
      (tick & ~miss_max) ? missed_pdu_count + 1'b1 : missed_pdu_count;
  wire next_lost = (loss_mult != '0) & (missed_pdu_count >= loss_lim);

  // sticky events
  logic [STK_W-1:0] stk_set;
  always_comb begin
    stk_set                 = '0;
    stk_set[STK_CC_RX]      = cc_ok;
    stk_set[STK_CV_RX]      = cv_ok;
    stk_set[STK_SRC_MULT]   = cc_ok & ~rx_far & chg_m;
    stk_set[STK_SRC_STATE]  = cc_ok & ~rx_far & chg_s;
    stk_set[STK_SRC_DIAG]   = cc_ok & ~rx_far & chg_d;
    stk_set[STK_SINK_MULT]  = cc_ok & rx_far & chg_m;
    stk_set[STK_SINK_STATE] = cc_ok & rx_far & chg_s;
    stk_set[STK_SINK_DIAG]  = cc_ok & rx_far & chg_d;
    stk_set[STK_SRC_POLL]   = cc_ok & ~rx_far & rx_poll;
    stk_set[STK_SRC_FINAL]  = cc_ok & ~rx_far & rx_final;
    stk_set[STK_SINK_POLL]  = ((cc_ok & rx_far) | cv_ok) & rx_poll;
    stk_set[STK_SINK_FINAL] = ((cc_ok & rx_far) | cv_ok) & rx_final;
    stk_set[STK_CONT_CHG]   = next_lost != continuity_lost_state;
    stk_set[STK_TX_MISM]    = tx_mism;
  end
  // set wins over a clear in the same cycle
  wire [STK_W-1:0] next_sticky = (sticky & ~stk_clear) | stk_set;
  wire             next_irq    = |(next_sticky & interrupt_enable_set & IRQ_CAPABLE);

  // apb slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= ZERO32;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      prdata  <= (apb_setup & ~pwrite) ? rd_mux : ZERO32;
    end
  end

  // configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg                 <= CFG_RESET;
      extract_reg                <= EX_RESET;
      local_source_discriminator <= ZERO32;
      local_sink_discriminator   <= ZERO32;
      interrupt_enable_set       <= '0;
    end else begin
      extract_reg <= next_extract;
      if (apb_wr & hit_cfg) begin
        config_reg <= pwdata[CFG_W-1:0];
      end
      if (apb_wr & hit_sdis) begin
        local_source_discriminator <= pwdata;
      end
      if (apb_wr & hit_kdis) begin
        local_sink_discriminator <= pwdata;
      end
      if (apb_wr & hit_ien) begin
        interrupt_enable_set <= pwdata[STK_W-1:0];
      end
    end
  end

  // session info: local by software, remote by sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_state <= '0;
      loc_diag  <= '0;
      loc_mult  <= '0;
      rem_state <= '0;
      rem_diag  <= '0;
      rem_mult  <= '0;
    end else begin
      if (apb_wr & hit_sinf) begin
        loc_state[0] <= pwdata[INF_LSTATE +: STATE_W];
        loc_diag[0]  <= pwdata[INF_LDIAG  +: DIAG_W];
        loc_mult[0]  <= pwdata[INF_LMULT  +: MULT_W];
      end
      if (apb_wr & hit_kinf) begin
        loc_state[1] <= pwdata[INF_LSTATE +: STATE_W];
        loc_diag[1]  <= pwdata[INF_LDIAG  +: DIAG_W];
        loc_mult[1]  <= pwdata[INF_LMULT  +: MULT_W];
      end
      if (do_sample) begin
        rem_state[rx_side] <= rx_state;
        rem_diag[rx_side]  <= rx_diag;
        rem_mult[rx_side]  <= rx_mult;
      end
    end
  end

  // status, counters, interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky                <= '0;
      missed_pdu_count      <= '0;
      continuity_lost_state <= 1'b0;
      cc_tx_count           <= ZERO32;
      cv_tx_count           <= ZERO32;
      irq                   <= 1'b0;
    end else begin
      sticky                <= next_sticky;
      missed_pdu_count      <= next_missed_pdu_count;
      continuity_lost_state <= next_lost;
      irq                   <= next_irq;
      if (tx_pdu_valid & ~tx_mism & ~tx_pdu_is_cv) begin
        cc_tx_count <= cc_tx_count + 32'h0000_0001;
      end
      if (tx_pdu_valid & ~tx_mism & tx_pdu_is_cv) begin
        cv_tx_count <= cv_tx_count + 32'h0000_0001;
      end
    end
  end

  // rx extraction and tx rewrite outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_extract_valid <= 1'b0;
      rx_extract_queue <= Q_CC;
      tx_out_valid     <= 1'b0;
      tx_out_discard   <= 1'b0;
      tx_out_state     <= '0;
      tx_out_diag      <= '0;
      tx_out_mult      <= '0;
      tx_extract_valid <= 1'b0;
    end else begin
      rx_extract_valid <= rx_extract;
      rx_extract_queue <= rx_queue;
      tx_out_valid     <= tx_pdu_valid & ~tx_mism;
      tx_out_discard   <= tx_mism;
      tx_extract_valid <= hit_txerr;
      tx_out_state     <= tx_rw ? loc_state[tx_side] : tx_state;
      tx_out_diag      <= tx_rw ? loc_diag[tx_side]  : tx_diag;
      tx_out_mult      <= tx_rw ? loc_mult[tx_side]  : tx_mult;
    end
  end

endmodule // bsm_session_monitor
`default_nettype wire

// ===== dv/bsm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bsm_properties
  import bsm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  // rx side
  input  wire logic        rx_pdu_valid,
  input  wire logic        rx_pdu_ok,
  input  wire logic        rx_pdu_is_cv,
  input  wire logic        rx_extract_valid,
  input  wire logic [1:0]  rx_extract_queue,
  // tx side
  input  wire logic        tx_pdu_valid,
  input  wire logic        tx_out_valid,
  input  wire logic        tx_out_discard,
  input  wire logic        tx_extract_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_extract_cause: assert property (rx_extract_valid |-> $past(rx_pdu_valid))
    else $error("extraction without a received pdu");
  chk_err_queue: assert property (
    rx_pdu_valid && !rx_pdu_ok ##1 rx_extract_valid |-> rx_extract_queue == Q_ERR)
    else $error("invalid pdu not in error queue");
  chk_cv_queue: assert property (
    rx_pdu_valid && rx_pdu_ok && rx_pdu_is_cv ##1 rx_extract_valid |-> rx_extract_queue == Q_CV)
    else $error("valid cv pdu in wrong queue");
  chk_cc_queue: assert property (
    rx_pdu_valid && rx_pdu_ok && !rx_pdu_is_cv ##1 rx_extract_valid |-> rx_extract_queue == Q_CC)
    else $error("valid cc pdu in wrong queue");
  chk_tx_answer: assert property (tx_pdu_valid |=> tx_out_valid != tx_out_discard)
    else $error("tx pdu neither forwarded nor discarded once");
  chk_tx_quiet: assert property (!tx_pdu_valid |=> !(tx_out_valid || tx_out_discard))
    else $error("tx output without tx pdu");
  chk_tx_extract: assert property (tx_extract_valid |-> tx_out_discard)
    else $error("tx extraction of a forwarded pdu");
  chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  chk_read_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access phase");

  cover property (rx_extract_valid && rx_extract_queue == Q_ERR);
  cover property (tx_extract_valid);
  cover property (tx_pdu_valid ##1 tx_out_valid);
endmodule // bsm_properties

bind bsm_session_monitor bsm_properties u_chk (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .rx_pdu_valid, .rx_pdu_ok,
  .rx_pdu_is_cv, .rx_extract_valid, .rx_extract_queue, .tx_pdu_valid, .tx_out_valid,
  .tx_out_discard, .tx_extract_valid
);
`default_nettype wire

// ===== dv/bsm_cpu_queues.sv
`timescale 1ns/1ps
`default_nettype none
module bsm_cpu_queues
  import bsm_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // extraction from the monitor
  input  wire logic       rx_extract_valid,
  input  wire logic [1:0] rx_extract_queue,
  input  wire logic       tx_extract_valid,
  // frames per queue
  output logic      [7:0] n_cc,
  output logic      [7:0] n_cv,
  output logic      [7:0] n_err
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {n_cc, n_cv, n_err} <= 24'h00_0000;
    end else begin
      n_cc  <= n_cc + {7'h00, rx_extract_valid && rx_extract_queue == Q_CC};
      n_cv  <= n_cv + {7'h00, rx_extract_valid && rx_extract_queue == Q_CV};
      // failed tx pdus share the error queue
      n_err <= n_err + {7'h00, rx_extract_valid && rx_extract_queue == Q_ERR}
               + {7'h00, tx_extract_valid};
    end
  end
endmodule // bsm_cpu_queues
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import bsm_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_pdu_valid = 1'b0, rx_pdu_ok = 1'b0, rx_pdu_is_cv = 1'b0, rx_poll = 1'b0;
  logic rx_final = 1'b0, tx_pdu_valid = 1'b0, tx_pdu_is_cv = 1'b0, rx_pdu_far_end = 1'b0;
  logic [STATE_W-1:0] rx_state = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, tx_my_discr = 32'h0000_0000, prdata, rd;
  logic [DIAG_W-1:0] rx_diag = 5'h00, tx_out_diag;
  logic [MULT_W-1:0] rx_mult = 8'h00, tx_out_mult;
  logic [3:0] miss_timer_expired = 4'h0;
  logic pready, pslverr, err, ev, rx_extract_valid, tx_out_valid, tx_out_discard;
  logic tx_extract_valid, irq;
  logic [1:0] rx_extract_queue, eq;
  logic [STATE_W-1:0] tx_out_state;
  logic [17:0] tv;
  logic [7:0] n_cc, n_cv, n_err;
  // {ok, cv, poll, final, extracted, queue}
  logic [6:0] rows [4] = '{7'h54, 7'h6D, 7'h44, 7'h06};
  int fail_count = 0;
  int checks = 0;

  bsm_session_monitor u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_pdu_valid, .rx_pdu_ok, .rx_pdu_is_cv,
    .rx_pdu_far_end, .rx_state, .rx_diag, .rx_mult, .rx_poll, .rx_final,
    .rx_extract_valid, .rx_extract_queue, .tx_pdu_valid, .tx_pdu_is_cv, .tx_my_discr,
    .tx_state(2'h0), .tx_diag(5'h00), .tx_mult(8'h00), .tx_out_valid, .tx_out_discard,
    .tx_out_state, .tx_out_diag, .tx_out_mult, .tx_extract_valid, .miss_timer_expired, .irq);
  bsm_cpu_queues u_q (.pclk, .presetn, .rx_extract_valid, .rx_extract_queue,
    .tx_extract_valid, .n_cc, .n_cv, .n_err);

  always #5 pclk = ~pclk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // look at the registered answer mid-cycle; it stands until the commit edge
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(negedge pclk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk({err, rd}, e);
  endtask

  // upstream supplies verdict and type with each pdu
  task automatic pdu(input logic [3:0] k, input logic [7:0] m);
    {rx_pdu_ok, rx_pdu_is_cv, rx_poll, rx_final, rx_mult, rx_diag} <= {k, m, m[4:0]};
    rx_pdu_valid <= 1'b1;
    @(posedge pclk);
    rx_pdu_valid <= 1'b0;
    @(negedge pclk);
    {ev, eq} = {rx_extract_valid, rx_extract_queue};
    @(posedge pclk);
  endtask

  // one pdu at a time, at the rate the bench chooses
  task automatic txp(input logic [31:0] dsc);
    {tx_my_discr, tx_pdu_valid} <= {dsc, 1'b1};
    @(posedge pclk);
    tx_pdu_valid <= 1'b0;
    @(negedge pclk);
    tv = {tx_out_valid, tx_out_discard, tx_extract_valid, tx_out_state, tx_out_diag, tx_out_mult};
    @(posedge pclk);
  endtask

  task automatic miss(input int k);
    repeat (k) begin
      miss_timer_expired <= 4'h1;
      @(posedge pclk);
      miss_timer_expired <= 4'h0;
      @(posedge pclk);
    end
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, OFS_CONFIG, 32'h0000_0040);
    apb(1'b1, OFS_EXTRACT, 32'h0000_0070);
    foreach (rows[i]) begin
      pdu(rows[i][6:3], 8'h00);
      chk({ev, ev ? eq : 2'h0}, rows[i][2:0]);
    end
    $display("rx table done");
    apb(1'b1, OFS_CONFIG, 32'h0000_0009);
    pdu(4'h8, 8'h03);
    rc(OFS_SRC_INFO, 33'h0_030C_0000);
    rc(OFS_STICKY, 33'h0_0000_0837);
    chk(irq, 1'b0);
    apb(1'b1, OFS_IRQ_ENA, 32'h0000_1000);
    apb(1'b1, OFS_STICKY, 32'h0000_3FFF);
    miss(5);
    rc(OFS_STATUS, 33'h0_0000_0005);
    miss(1);
    rc(OFS_STATUS, 33'h0_0001_0006);
    chk(irq, 1'b1);
    rc(OFS_STICKY, 33'h0_0000_1000);
    pdu(4'h8, 8'h03);
    rc(OFS_STATUS, 33'h0_0000_0000);
    $display("continuity loss done");
    apb(1'b1, OFS_EXTRACT, 32'h0000_0001);
    pdu(4'h8, 8'h03);
    chk({ev, eq}, {1'b1, Q_CC});
    rc(OFS_EXTRACT, 33'h0_0000_0000);
    pdu(4'h8, 8'h03);
    chk(ev, 1'b0);
    $display("next good done");
    apb(1'b1, OFS_SRC_DISCR, 32'h1234_5678);
    apb(1'b1, OFS_SRC_INFO, 32'h0000_0547);
    apb(1'b1, OFS_EXTRACT, 32'h0000_0080);
    txp(32'h1234_5678);
    chk(tv, {3'h4, 2'h3, 5'h11, 8'h05});
    txp(32'h0000_0000);
    chk(tv[17:15], 3'h3);
    rc(OFS_CC_TX_CNT, 33'h0_0000_0001);
    apb(1'b1, OFS_CONFIG, 32'h0000_000B);
    apb(1'b1, OFS_SINK_DISCR, 32'hAAAA_0001);
    apb(1'b1, OFS_SINK_INFO, 32'h0000_0201);
    tx_pdu_is_cv <= 1'b1;
    txp(32'hAAAA_0001);
    chk(tv, {3'h4, 2'h1, 5'h00, 8'h02});
    rc(OFS_CV_TX_CNT, 33'h0_0000_0001);
    rc(OFS_STICKY, 33'h0_0000_3001);
    // far-end cc pdu in independent mode with discriminator checking on
    apb(1'b1, OFS_STICKY, 32'h0000_3FFF);
    apb(1'b1, OFS_CONFIG, 32'h0000_0007);
    {rx_pdu_far_end, rx_state} <= 3'h5;
    pdu(4'hA, 8'h03);
    rc(OFS_SINK_INFO, 33'h0_030D_0201);
    rc(OFS_STICKY, 33'h0_0000_0781);
    rc(8'h2C, 33'h1_0000_0000);
    chk({n_cc, n_cv, n_err}, {8'h03, 8'h01, 8'h02});
    $display("tx and queues done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(OFS_CONFIG, 33'h0_0000_0000);
    rc(OFS_STICKY, 33'h0_0000_0000);
    $display("reset done");
    complete_run;
  end
endmodule // tb
`default_nettype wire
